// file: hw/page0_regs_pkg.sv
// Constants shared by the page-0 command and status register front end.
// Assumes one system clock; every user writes package::name, nothing is imported.
package page0_regs_pkg;

    // Register offsets within page 0, as seen on the effective register address.
    localparam logic [5:0] PAGE_WINDOW_SELECT_OFS = 6'h00;
    localparam logic [5:0] OPERATION_CONTROL_OFS = 6'h01;
    localparam logic [5:0] FIFO_BYTE_PORT_OFS = 6'h02;

    // The paging register repeats every eight addresses; these low bits pick it out.
    localparam logic [2:0] PAGE_LOW_BITS = 3'h0;

    // Field positions.
    localparam int PAGE_BITS_ENABLE_POS = 7;
    localparam int PAGE_NUMBER_LSB = 0;
    localparam int PAGE_NUMBER_W = 3;
    localparam int DETECT_BUSY_POS = 7;
    localparam int CMD_CODE_LSB = 0;
    localparam int CMD_CODE_W = 6;

    // Reset values.
    localparam logic [7:0] PAGE_WINDOW_SELECT_RST = 8'h80;
    localparam logic [5:0] CMD_CODE_RST = 6'h00;
    localparam logic [6:0] FIFO_FILL_COUNT_RST = 7'h00;

    // Staging buffer geometry.
    localparam int FIFO_DEPTH = 64;
    localparam int FIFO_AW = 6;
    localparam int FIFO_COUNT_W = 7;

endpackage : page0_regs_pkg

// file: hw/fifo_mem_if.sv
// Carrier between the register front end and its byte memory.
// Assumes both ends share clk_sys_i; read data lag the read strobe by one cycle.
`timescale 1ns/100ps
interface fifo_mem_if #(
    parameter int DATA_W = 8,
    parameter int ADDR_W = 6
) ();
    logic wr_en;
    logic [ADDR_W-1:0] wr_addr;
    logic [DATA_W-1:0] wr_data;
    logic rd_en;
    logic [ADDR_W-1:0] rd_addr;
    logic [DATA_W-1:0] rd_data;

    modport ctrl (output wr_en, output wr_addr, output wr_data,
                  output rd_en, output rd_addr, input rd_data);
    modport mem (input wr_en, input wr_addr, input wr_data,
                 input rd_en, input rd_addr, output rd_data);
endinterface : fifo_mem_if

// file: hw/fifo_byte_mem.sv
// Simple dual-port byte memory behind the staging buffer.
// Assumes one clock; read data come out of a register one cycle after rd_en.
`timescale 1ns/100ps
module fifo_byte_mem #(
    parameter int DATA_W = 8,
    parameter int DEPTH = 64,
    parameter int ADDR_W = 6
) (
    input wire logic clk_sys_i,
    fifo_mem_if.mem port
);
    logic [DATA_W-1:0] mem_q [DEPTH];
    logic [DATA_W-1:0] rd_data_r;

    // Storage has no reset; the pointers in the front end decide what is valid.
    always_ff @(posedge clk_sys_i) begin
        if (port.wr_en) begin
            mem_q[port.wr_addr] <= port.wr_data;
        end
        if (port.rd_en) begin
            rd_data_r <= mem_q[port.rd_addr];
        end
    end

    assign port.rd_data = rd_data_r;

endmodule : fifo_byte_mem

// file: hw/page0_command_status_regs.sv
// Page-0 front end: paging register, operation control register, FIFO byte port.
// Assumes the host strobes are already in clk_sys_i's domain and one at a time.
// Contract
// - Paging register decoded at every eighth address.
// - Page enable: page number forms address bits 5..3.
// - Page disabled: latch address used unchanged.
// - Reset loads paging register with 80h.
// - Writing code field starts that operation.
// - Reading returns code of running operation.
// - Bit 7 shows host detection still busy.
// - After reset code field and bit 6 zero.
// - Byte port at 02h pushes and pops FIFO.
// - FIFO shared with internal transmit/receive/command logic.
// - Seven-bit fill count follows pushes and pops.
`timescale 1ns/100ps
module page0_command_status_regs #(
    parameter int FIFO_DEPTH = page0_regs_pkg::FIFO_DEPTH
) (
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic [5:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    output logic reg_rvalid_o,
    output logic [5:0] reg_addr_eff_o,
    output logic cmd_start_o,
    output logic [5:0] cmd_code_o,
    input wire logic cmd_done_i,
    input wire logic host_port_detect_busy_i,
    input wire logic int_push_i,
    input wire logic [7:0] int_push_data_i,
    output logic int_push_ready_o,
    input wire logic int_pop_i,
    output logic int_pop_ready_o,
    output logic [7:0] int_pop_data_o,
    output logic int_pop_valid_o,
    output logic [6:0] fifo_fill_count_o
);
    localparam logic [6:0] DEPTH_C = 7'(FIFO_DEPTH);

    typedef struct packed {
        logic page_bits_enable;
        logic [2:0] page_number;
        logic [5:0] cmd_code;
        logic cmd_start;
        logic [7:0] rdata;
        logic rvalid;
        logic rsrc_fifo;
        logic ipop_valid;
        logic [5:0] wr_ptr;
        logic [5:0] rd_ptr;
        logic [6:0] fifo_fill_count;
    } state_type;

    state_type st_r;
    state_type st_nxt;
    logic [5:0] eff_addr;
    logic page_hit;
    logic cmd_hit;
    logic fifo_hit;
    logic host_push;
    logic host_pop;
    logic do_push;
    logic do_pop;

    fifo_mem_if #(.DATA_W(8), .ADDR_W(6)) mem_bus ();

    // Paging register answers wherever the low three address bits are zero.
    function automatic logic is_page_addr(input logic [5:0] a);
        is_page_addr = (a[2:0] == page0_regs_pkg::PAGE_LOW_BITS);
    endfunction : is_page_addr

    // Effective address and register decode.
    always_comb begin
        if (st_r.page_bits_enable) begin
            eff_addr = {st_r.page_number, reg_addr_i[2:0]};
        end else begin
            eff_addr = reg_addr_i;
        end
        page_hit = is_page_addr(eff_addr);
        cmd_hit = (eff_addr == page0_regs_pkg::OPERATION_CONTROL_OFS);
        fifo_hit = (eff_addr == page0_regs_pkg::FIFO_BYTE_PORT_OFS);
    end

    // The host has priority on both memory ports; the internal side is stalled instead.
    assign host_push = reg_wr_i && fifo_hit && (st_r.fifo_fill_count < DEPTH_C);
    assign host_pop = reg_rd_i && fifo_hit && (st_r.fifo_fill_count != 7'h00);
    assign int_push_ready_o = !(reg_wr_i && fifo_hit) && (st_r.fifo_fill_count < DEPTH_C);
    assign int_pop_ready_o = !(reg_rd_i && fifo_hit) && (st_r.fifo_fill_count != 7'h00);
    assign do_push = host_push || (int_push_i && int_push_ready_o);
    assign do_pop = host_pop || (int_pop_i && int_pop_ready_o);

    // Memory port drive: one writer and one reader per cycle.
    always_comb begin
        mem_bus.wr_en = do_push;
        mem_bus.wr_addr = st_r.wr_ptr;
        mem_bus.wr_data = host_push ? reg_wdata_i : int_push_data_i;
        mem_bus.rd_en = do_pop;
        mem_bus.rd_addr = st_r.rd_ptr;
    end

    // Next-state logic for the whole front end.
    always_comb begin
        st_nxt = st_r;
        st_nxt.cmd_start = 1'b0;
        st_nxt.rvalid = reg_rd_i;
        st_nxt.rsrc_fifo = host_pop;
        st_nxt.ipop_valid = do_pop && !host_pop;
        st_nxt.rdata = 8'h00;
        // A finishing operation drops back to idle, but a new start in the same cycle wins.
        if (cmd_done_i) begin
            st_nxt.cmd_code = page0_regs_pkg::CMD_CODE_RST;
        end
        if (reg_wr_i && page_hit) begin
            st_nxt.page_bits_enable = reg_wdata_i[page0_regs_pkg::PAGE_BITS_ENABLE_POS];
            st_nxt.page_number = reg_wdata_i[page0_regs_pkg::PAGE_NUMBER_LSB +:
                                             page0_regs_pkg::PAGE_NUMBER_W];
        end
        if (reg_wr_i && cmd_hit) begin
            st_nxt.cmd_code = reg_wdata_i[page0_regs_pkg::CMD_CODE_LSB +:
                                          page0_regs_pkg::CMD_CODE_W];
            st_nxt.cmd_start = 1'b1;
        end
        // Read data: reserved bits are zero, unmapped addresses answer zero.
        if (reg_rd_i && page_hit) begin
            st_nxt.rdata = {st_r.page_bits_enable, 4'h0, st_r.page_number};
        end else if (reg_rd_i && cmd_hit) begin
            st_nxt.rdata = {host_port_detect_busy_i, 1'b0, st_r.cmd_code};
        end
        if (do_push) begin
            st_nxt.wr_ptr = st_r.wr_ptr + 6'h01;
        end
        if (do_pop) begin
            st_nxt.rd_ptr = st_r.rd_ptr + 6'h01;
        end
        // Fill count moves by one per push and per pop; both together leave it.
        case ({do_push, do_pop})
            2'b10: st_nxt.fifo_fill_count = st_r.fifo_fill_count + 7'h01;
            2'b01: st_nxt.fifo_fill_count = st_r.fifo_fill_count - 7'h01;
            default: st_nxt.fifo_fill_count = st_r.fifo_fill_count;
        endcase
    end

    // State register with synchronous reset.
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            st_r <= '0;
            st_r.page_bits_enable <= page0_regs_pkg::PAGE_WINDOW_SELECT_RST[7];
            st_r.page_number <= page0_regs_pkg::PAGE_WINDOW_SELECT_RST[2:0];
            st_r.cmd_code <= page0_regs_pkg::CMD_CODE_RST;
            st_r.fifo_fill_count <= page0_regs_pkg::FIFO_FILL_COUNT_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    fifo_byte_mem #(.DATA_W(8), .DEPTH(FIFO_DEPTH), .ADDR_W(6)) u_mem (
        .clk_sys_i(clk_sys_i),
        .port(mem_bus.mem)
    );

    // Outputs; popped bytes come straight from the memory's output register.
    assign reg_rdata_o = st_r.rsrc_fifo ? mem_bus.rd_data : st_r.rdata;
    assign reg_rvalid_o = st_r.rvalid;
    assign reg_addr_eff_o = eff_addr;
    assign cmd_start_o = st_r.cmd_start;
    assign cmd_code_o = st_r.cmd_code;
    assign int_pop_data_o = mem_bus.rd_data;
    assign int_pop_valid_o = st_r.ipop_valid;
    assign fifo_fill_count_o = st_r.fifo_fill_count;

    // Checks on the front end, all on the system clock.
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);

    page_reset_a: assert property (disable iff (1'b0)
        sys_rst_i |=> (st_r.page_bits_enable && st_r.page_number == 3'h0))
        else $error("Paging register not 80h after reset.");

    cmd_reset_a: assert property (disable iff (1'b0)
        sys_rst_i |=> (cmd_code_o == 6'h00 && !cmd_start_o))
        else $error("Operation code not cleared by reset.");

    page_alias_a: assert property (
        (reg_wr_i && reg_addr_i[2:0] == 3'h0) |=>
        (st_r.page_bits_enable == $past(reg_wdata_i[7]) &&
         st_r.page_number == $past(reg_wdata_i[2:0])))
        else $error("Paging register write missed at an aliased address.");

    paged_addr_a: assert property (
        st_r.page_bits_enable |->
        (reg_addr_eff_o == {st_r.page_number, reg_addr_i[2:0]}))
        else $error("Paged address not formed from page number.");

    latch_addr_a: assert property (
        !st_r.page_bits_enable |-> (reg_addr_eff_o == reg_addr_i))
        else $error("Unpaged address differs from latch address.");

    cmd_start_a: assert property (
        (reg_wr_i && cmd_hit) |=> (cmd_start_o && cmd_code_o == $past(reg_wdata_i[5:0]))
        ##1 (!cmd_start_o || $past(reg_wr_i && cmd_hit)))
        else $error("Operation write did not start exactly one pulse.");

    cmd_readback_a: assert property (
        (reg_rd_i && cmd_hit) |=> (reg_rvalid_o &&
        reg_rdata_o == {$past(host_port_detect_busy_i), 1'b0, $past(cmd_code_o)}))
        else $error("Operation register read back wrong.");

    reserved_zero_a: assert property (
        (reg_rd_i && page_hit) |=> (reg_rvalid_o && reg_rdata_o[6:3] == 4'h0))
        else $error("Reserved paging bits not zero on read.");

    fill_up_a: assert property (
        (host_push && !do_pop) |=> (fifo_fill_count_o == $past(fifo_fill_count_o) + 7'h01))
        else $error("Fill count did not rise on a byte push.");

    fill_down_a: assert property (
        (host_pop && !do_push) |=> (fifo_fill_count_o == $past(fifo_fill_count_o) - 7'h01))
        else $error("Fill count did not fall on a byte pop.");

    fifo_echo_a: assert property (
        (host_push && fifo_fill_count_o == 7'h00 && !do_pop) ##1 (!do_push && !do_pop) ##1
        (reg_rd_i && fifo_hit && !int_pop_i) |=>
        (reg_rvalid_o && reg_rdata_o == $past(reg_wdata_i, 3)))
        else $error("Byte read from empty-then-filled FIFO not the byte written.");

    fill_bound_a: assert property (
        fifo_fill_count_o <= DEPTH_C)
        else $error("Fill count above buffer depth.");

    page_switch_c: cover property (reg_wr_i && page_hit && !reg_wdata_i[7]);
    cmd_run_c: cover property (cmd_start_o ##[1:20] cmd_done_i);
    fifo_full_c: cover property (fifo_fill_count_o == DEPTH_C);
    shared_pop_c: cover property (int_pop_valid_o ##1 (reg_rvalid_o && st_r.rsrc_fifo));

endmodule : page0_command_status_regs

// file: sim/host_port_model.sv
// Behavioural 8-bit host on the parallel register port of the page-0 block.
// Assumes strobes are launched on the falling edge and sampled on the next rising edge.
`timescale 1ns/100ps
module host_port_model (
    input wire logic clk_sys_i,
    input wire logic [7:0] reg_rdata_i,
    input wire logic reg_rvalid_i,
    output logic [5:0] reg_addr_o,
    output logic reg_wr_o,
    output logic reg_rd_o,
    output logic [7:0] reg_wdata_o
);
    // Bus idles with no strobe; the address latch keeps its last value like a real latch.
    initial begin
        reg_addr_o = 6'h00;
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
        reg_wdata_o = 8'h00;
    end

    // One write; data is scrambled after release so a late sample shows up as wrong.
    task automatic wr_reg(input logic [5:0] addr, input logic [7:0] data);
        @(negedge clk_sys_i);
        reg_addr_o = addr;
        reg_wdata_o = data;
        reg_wr_o = 1'b1;
        @(negedge clk_sys_i);
        reg_wr_o = 1'b0;
        reg_wdata_o = ~data;
    endtask : wr_reg

    // One read; the answer stands for one cycle and is taken while it stands.
    task automatic rd_reg(input logic [5:0] addr, output logic [7:0] data, output logic ok);
        @(negedge clk_sys_i);
        reg_addr_o = addr;
        reg_rd_o = 1'b1;
        @(negedge clk_sys_i);
        reg_rd_o = 1'b0;
        ok = reg_rvalid_i;
        data = reg_rdata_i;
    endtask : rd_reg
endmodule : host_port_model

// file: sim/tb.sv
// Self-checking bench for the page-0 command and status register front end.
// Assumes the host model drives the register port; the bench plays the internal logic.
`timescale 1ns/100ps
module tb;
    logic clk_sys_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [5:0] addr, eff, code;
    logic wr, rd, rvalid, start, done = 1'b0, busy = 1'b1;
    logic [7:0] wdata, rdata, pdata = 8'h00, popd;
    logic push = 1'b0, pop = 1'b0, pvalid, pushr, popr;
    logic [6:0] cnt;
    int failures = 0;
    int check_count = 0;

    // Free-running 100 MHz clock.
    always #5 clk_sys_i = ~clk_sys_i;

    host_port_model i_host (.clk_sys_i(clk_sys_i), .reg_rdata_i(rdata), .reg_rvalid_i(rvalid),
        .reg_addr_o(addr), .reg_wr_o(wr), .reg_rd_o(rd), .reg_wdata_o(wdata));

    page0_command_status_regs i_dut (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
        .reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wdata),
        .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .reg_addr_eff_o(eff),
        .cmd_start_o(start), .cmd_code_o(code), .cmd_done_i(done),
        .host_port_detect_busy_i(busy), .int_push_i(push), .int_push_data_i(pdata),
        .int_push_ready_o(pushr), .int_pop_i(pop), .int_pop_ready_o(popr), .int_pop_data_o(popd),
        .int_pop_valid_o(pvalid), .fifo_fill_count_o(cnt));

    // Compare one value and count it; a mismatch is reported at once.
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    // Host read that also insists on the one-cycle answer strobe.
    task automatic rd_chk(input logic [5:0] a, input logic [7:0] exp, input string what);
        logic [7:0] d;
        logic ok;
        i_host.rd_reg(a, d, ok);
        chk({7'h00, ok}, 8'h01, "read answer");
        chk(d, exp, what);
    endtask : rd_chk

    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : conclude

    task automatic t_reset();
        rd_chk(6'h00, 8'h80, "paging after reset");
        rd_chk(6'h01, 8'h80, "control while detecting");
        busy = 1'b0;
        rd_chk(6'h01, 8'h00, "control after detection");
        $display("test reset done");
    endtask : t_reset

    task automatic t_paging();
        i_host.wr_reg(6'h00, 8'hFD);
        rd_chk(6'h08, 8'h85, "paging reserved bits");
        rd_chk(6'h03, 8'h00, "unmapped read");
        chk({2'h0, eff}, 8'h2B, "effective address paged");
        i_host.wr_reg(6'h10, 8'h05);
        chk({2'h0, eff}, 8'h10, "effective address latch");
        for (int k = 0; k < 8; k++) begin
            i_host.wr_reg(6'(k * 8), 8'(k));
            rd_chk(6'(k * 8), 8'(k), "paging at each base");
        end
        i_host.wr_reg(6'h38, 8'h80);
        $display("test paging done");
    endtask : t_paging

    task automatic t_command();
        i_host.wr_reg(6'h01, 8'hDA);
        chk({7'h00, start}, 8'h01, "start pulse");
        chk({2'h0, code}, 8'h1A, "running code");
        @(negedge clk_sys_i);
        chk({7'h00, start}, 8'h00, "start one cycle");
        rd_chk(6'h01, 8'h1A, "control readback");
        done = 1'b1;
        @(negedge clk_sys_i);
        done = 1'b0;
        rd_chk(6'h01, 8'h00, "control after done");
        $display("test command done");
    endtask : t_command

    // Fill until the buffer refuses, then drain past empty.
    task automatic t_fifo();
        i_host.wr_reg(6'h02, 8'h77);
        rd_chk(6'h02, 8'h77, "byte echo");
        for (int i = 0; i < 64; i++) i_host.wr_reg(6'h02, 8'(i) ^ 8'h5A);
        chk({1'b0, cnt}, 8'h40, "count full");
        chk({7'h00, pushr}, 8'h00, "internal push refused when full");
        i_host.wr_reg(6'h02, 8'hFF);
        chk({1'b0, cnt}, 8'h40, "count after refused push");
        for (int i = 0; i < 64; i++) rd_chk(6'h02, 8'(i) ^ 8'h5A, "fifo order");
        rd_chk(6'h02, 8'h00, "empty read");
        chk({1'b0, cnt}, 8'h00, "count empty");
        chk({7'h00, popr}, 8'h00, "internal pop refused when empty");
        $display("test fifo done");
    endtask : t_fifo

    // Internal side pushes and pops through the same buffer as the host.
    task automatic t_shared();
        @(negedge clk_sys_i);
        push = 1'b1;
        pdata = 8'hA5;
        @(negedge clk_sys_i);
        pdata = 8'h3C;
        @(negedge clk_sys_i);
        push = 1'b0;
        chk({1'b0, cnt}, 8'h02, "count after internal push");
        chk({6'h00, pushr, popr}, 8'h03, "internal ready with room and data");
        rd_chk(6'h02, 8'hA5, "host pops internal byte");
        rd_chk(6'h02, 8'h3C, "host pops second byte");
        i_host.wr_reg(6'h02, 8'hC3);
        pop = 1'b1;
        @(negedge clk_sys_i);
        pop = 1'b0;
        chk({7'h00, pvalid}, 8'h01, "internal pop valid");
        chk(popd, 8'hC3, "internal pops host byte");
        $display("test shared done");
    endtask : t_shared

    // Whole run is a few hundred cycles; the watchdog allows ample margin.
    initial begin
        #200000;
        failures++;
        $display("[ERR] %0t watchdog expired", $time);
        conclude();
    end

    initial begin
        repeat (10) @(negedge clk_sys_i);
        sys_rst_i = 1'b0;
        t_reset();
        t_paging();
        t_command();
        t_fifo();
        t_shared();
        conclude();
    end
endmodule : tb
